// *** ppl_consts.svh ***
// constants of the probe position latch: register indices, fields, resets
// assumes an APB slave with one 32-bit word per register index
`ifndef PPL_CONSTS_SVH
`define PPL_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PPL_IDX_POLARITY  16'h2007
`define PPL_IDX_CTRL      16'h60b8
`define PPL_IDX_STATUS    16'h60b9
`define PPL_IDX_P1_RPOS   16'h60ba
`define PPL_IDX_P1_FPOS   16'h60bb
`define PPL_IDX_P2_RPOS   16'h60bc
`define PPL_IDX_P2_FPOS   16'h60bd
`define PPL_IDX_P1_RCNT   16'h60d5
`define PPL_IDX_P1_FCNT   16'h60d6
`define PPL_IDX_P2_RCNT   16'h60d7
`define PPL_IDX_P2_FCNT   16'h60d8
`define PPL_IDX_IRQ_STAT  16'h60c0
`define PPL_IDX_IRQ_MASK  16'h60c1

// ----------------------------------------------------------------
// field positions, per channel byte
// ----------------------------------------------------------------
`define PPL_CH_STRIDE     8
`define PPL_CB_ENABLE     0
`define PPL_CB_MODE       1
`define PPL_CB_SOURCE     2
`define PPL_CB_RISE       4
`define PPL_CB_FALL       5
`define PPL_SB_ENABLE     0
`define PPL_SB_RISE       1
`define PPL_SB_FALL       2
`define PPL_CHG_MASK      8'h35
`define PPL_CTRL_MASK     16'h3737

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPL_RST_CTRL      16'h0000
`define PPL_RST_POLARITY  2'h3
`define PPL_RST_IRQ       4'h0

`endif

// *** ppl_pkg.sv ***
// types of the probe position latch
// assumes ppl_consts.svh holds the numbers
package ppl_pkg;

   // one channel's byte of the control word
   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic       fall_en;
      logic       rise_en;
      logic       rsvd_lo;
      logic       src_index;
      logic       cont_mode;
      logic       enable;
   } ppl_cfg_s;

   // latch events of one channel in one cycle
   typedef struct packed {
      logic rise;
      logic fall;
   } ppl_hit_s;

   // arming state, gray along disabled -> armed -> spent
   typedef enum logic [1:0] {
      PPL_DISABLED = 2'h0,
      PPL_ARMED    = 2'h1,
      PPL_SPENT    = 2'h3
   } ppl_arm_e;

endpackage : ppl_pkg

// *** ppl_probe_latch.sv ***
// two-channel touch-probe position latch with APB register access
// assumes POSITION is on CORE_CLK; probe and index pins are asynchronous
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "ppl_consts.svh"

// Operation
// - Status bit 0 shows channel 1 enable, bit 1 its rise latch done, bit 2 its fall latch done.
// - Status bit 8 shows channel 2 enable, bit 9 its rise latch done, bit 10 its fall latch done.
// - Channel 1 keeps its rising and falling captured positions in two read-only registers.
// - Channel 2 keeps its rising and falling captured positions in two read-only registers.
// - Channel 1 counts its rising and its falling latch events in two read-only counters.
// - Channel 2 counts its rising and its falling latch events in two read-only counters.
// - Control bit 1 or 9 picks single-trigger mode at 0 and continuous mode at 1.
// - In single-trigger mode only the first valid trigger after arming is latched.
// - Clearing and then setting the enable bit re-arms a single-trigger channel.
// - In continuous mode a latched position holds until the next valid trigger.
// - In continuous mode the channel stays armed after each capture.
// - Control low byte sets channel 1, high byte channel 2: enable, rise and fall enables.
// - Control bit 2 or 10 picks the probe pin at 0 and the encoder index at 1.
// - Changing enable, source or edge settings clears that channel's counters and flags.
// - Polarity bit 0 sets the active level of probe one, bit 1 that of probe two.
module ppl_probe_latch
   import ppl_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        NRST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // probe and index pins
   input  wire logic        PROBE_INPUT_ONE,
   input  wire logic        PROBE_INPUT_TWO,
   input  wire logic        ENC_INDEX,
   // live position
   input  wire logic [31:0] POSITION,
   // interrupt
   output logic             IRQ
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [2:0]  pin_raw;
   logic [2:0]  s1_q;
   logic [2:0]  s2_q;
   logic [2:0]  s3_q;
   logic [2:0]  lvl_q;
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [1:0]  pol_q;
   logic [3:0]  istat_q;
   logic [3:0]  istat_d;
   logic [3:0]  imask_q;
   logic [3:0]  irq_ev;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        slverr_q;
   logic        slverr_d;
   logic        wr_acc;
   logic        setup;
   logic        addr_ok;
   logic [15:0] word_idx;
   logic        ctrl_wr;
   logic [15:0] ctrl_diff;
   logic [15:0] status_w;
   logic [1:0]  chg_now;
   logic [1:0]  chg_q;
   logic [1:0]  prev_q;
   logic [1:0]  raw;
   logic [1:0]  rflag_q;
   logic [1:0]  fflag_q;
   ppl_hit_s    hit [2];
   ppl_cfg_s    cfg [2];
   ppl_arm_e    st_q [2];
   logic [31:0] rpos_q [2];
   logic [31:0] fpos_q [2];
   logic [31:0] rcnt_q [2];
   logic [31:0] fcnt_q [2];

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!NRST);

   // ----------------------------------------------------------------
   // pin synchronisers, a level counts once stages two and three agree
   // ----------------------------------------------------------------
   assign pin_raw = {ENC_INDEX, PROBE_INPUT_TWO, PROBE_INPUT_ONE};

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         s1_q  <= 3'h0;
         s2_q  <= 3'h0;
         s3_q  <= 3'h0;
         lvl_q <= 3'h0;
      end
      else
      begin
         s1_q  <= pin_raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         // agreeing stages update the level, disagreeing ones hold it
         lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      end
   end

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign PREADY   = 1'b1;
   assign setup    = PSEL & ~PENABLE;
   assign wr_acc   = PSEL & PENABLE & PWRITE;
   assign word_idx = PADDR[17:2];
   assign addr_ok  = (PADDR[31:18] == 14'h0) && (PADDR[1:0] == 2'h0);
   assign ctrl_wr  = wr_acc && addr_ok && (word_idx == `PPL_IDX_CTRL);
   assign PRDATA   = prdata_q;
   assign PSLVERR  = slverr_q & PSEL & PENABLE;

   // byte lanes: low byte channel 1, high byte channel 2
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (PSTRB[0])
         ctrl_d[7:0] = PWDATA[7:0];
      if (PSTRB[1])
         ctrl_d[15:8] = PWDATA[15:8];
      ctrl_d = ctrl_d & `PPL_CTRL_MASK;
   end

   assign ctrl_diff = (ctrl_d ^ ctrl_q) & {`PPL_CHG_MASK, `PPL_CHG_MASK};

   // a settings change clears the channel's counters and flags
   assign chg_now[0] = ctrl_wr && (ctrl_diff[7:0] != 8'h00);
   assign chg_now[1] = ctrl_wr && (ctrl_diff[15:8] != 8'h00);

   // read data and error are fetched in the setup cycle
   always_comb
   begin
      prdata_d = 32'h0;
      slverr_d = 1'b0;
      case (word_idx)
         `PPL_IDX_POLARITY : prdata_d = {30'h0, pol_q};
         `PPL_IDX_CTRL     : prdata_d = {16'h0, ctrl_q};
         `PPL_IDX_STATUS   :
         begin
            prdata_d = {16'h0, status_w};
            slverr_d = PWRITE;
         end
         `PPL_IDX_P1_RPOS  :
         begin
            prdata_d = rpos_q[0];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P1_FPOS  :
         begin
            prdata_d = fpos_q[0];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P2_RPOS  :
         begin
            prdata_d = rpos_q[1];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P2_FPOS  :
         begin
            prdata_d = fpos_q[1];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P1_RCNT  :
         begin
            prdata_d = rcnt_q[0];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P1_FCNT  :
         begin
            prdata_d = fcnt_q[0];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P2_RCNT  :
         begin
            prdata_d = rcnt_q[1];
            slverr_d = PWRITE;
         end
         `PPL_IDX_P2_FCNT  :
         begin
            prdata_d = fcnt_q[1];
            slverr_d = PWRITE;
         end
         `PPL_IDX_IRQ_STAT : prdata_d = {28'h0, istat_q};
         `PPL_IDX_IRQ_MASK : prdata_d = {28'h0, imask_q};
         default           : slverr_d = 1'b1;
      endcase
      if (!addr_ok)
      begin
         prdata_d = 32'h0;
         slverr_d = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         prdata_q <= 32'h0;
         slverr_q <= 1'b0;
      end
      else if (setup)
      begin
         prdata_q <= PWRITE ? 32'h0 : prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         ctrl_q <= `PPL_RST_CTRL;
      else if (ctrl_wr)
         ctrl_q <= ctrl_d;
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         pol_q <= `PPL_RST_POLARITY;
      else if (wr_acc && addr_ok && (word_idx == `PPL_IDX_POLARITY) && PSTRB[0])
         pol_q <= PWDATA[1:0];
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         imask_q <= `PPL_RST_IRQ;
      else if (wr_acc && addr_ok && (word_idx == `PPL_IDX_IRQ_MASK) && PSTRB[0])
         imask_q <= PWDATA[3:0];
   end

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, a new event wins
   // ----------------------------------------------------------------
   assign irq_ev = {hit[1].fall, hit[1].rise, hit[0].fall, hit[0].rise};

   always_comb
   begin
      istat_d = istat_q;
      if (wr_acc && addr_ok && (word_idx == `PPL_IDX_IRQ_STAT) && PSTRB[0])
         istat_d = istat_q & ~PWDATA[3:0];
      istat_d = istat_d | irq_ev;
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         istat_q <= `PPL_RST_IRQ;
      else
         istat_q <= istat_d;
   end

   assign IRQ = |(istat_q & imask_q);

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   // flags per channel, reserved bits zero
   always_comb
   begin
      status_w = 16'h0;
      for (int k = 0; k < 2; k++)
      begin
         status_w[k*`PPL_CH_STRIDE + `PPL_SB_ENABLE] = cfg[k].enable;
         status_w[k*`PPL_CH_STRIDE + `PPL_SB_RISE]   = rflag_q[k];
         status_w[k*`PPL_CH_STRIDE + `PPL_SB_FALL]   = fflag_q[k];
      end
   end

   a_status_rsvd : assert property (
      (status_w & 16'hf8f8) == 16'h0)
      else $error("reserved status bits not zero");

   // ----------------------------------------------------------------
   // per channel capture
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      assign cfg[i] = ppl_cfg_s'(ctrl_q[i*`PPL_CH_STRIDE +: `PPL_CH_STRIDE]);

      assign raw[i] = cfg[i].src_index ? lvl_q[2] : ~(lvl_q[i] ^ pol_q[i]);

      // edges across a settings change are not trusted
      assign hit[i].rise = (st_q[i] == PPL_ARMED) && !chg_now[i] && !chg_q[i]
                           && cfg[i].rise_en && raw[i] && !prev_q[i];
      assign hit[i].fall = (st_q[i] == PPL_ARMED) && !chg_now[i] && !chg_q[i]
                           && cfg[i].fall_en && !raw[i] && prev_q[i];

      always_ff @(posedge CORE_CLK or negedge NRST)
      begin
         if (!NRST)
         begin
            prev_q[i] <= 1'b0;
            chg_q[i]  <= 1'b0;
         end
         else
         begin
            prev_q[i] <= raw[i];
            chg_q[i]  <= chg_now[i];
         end
      end

      always_ff @(posedge CORE_CLK or negedge NRST)
      begin
         if (!NRST)
            st_q[i] <= PPL_DISABLED;
         else if (!cfg[i].enable)
            st_q[i] <= PPL_DISABLED;
         else
         begin
            case (st_q[i])
               PPL_DISABLED : st_q[i] <= PPL_ARMED;
               PPL_ARMED    :
                  if ((hit[i].rise || hit[i].fall) && !cfg[i].cont_mode)
                     st_q[i] <= PPL_SPENT;
               PPL_SPENT    :
                  if (cfg[i].cont_mode)
                     st_q[i] <= PPL_ARMED;
               default      : st_q[i] <= PPL_DISABLED;
            endcase
         end
      end

      always_ff @(posedge CORE_CLK or negedge NRST)
      begin
         if (!NRST)
         begin
            rpos_q[i] <= 32'h0;
            fpos_q[i] <= 32'h0;
         end
         else
         begin
            if (hit[i].rise)
               rpos_q[i] <= POSITION;
            if (hit[i].fall)
               fpos_q[i] <= POSITION;
         end
      end

      always_ff @(posedge CORE_CLK or negedge NRST)
      begin
         if (!NRST)
         begin
            rcnt_q[i] <= 32'h0;
            fcnt_q[i] <= 32'h0;
         end
         else if (chg_now[i])
         begin
            rcnt_q[i] <= 32'h0;
            fcnt_q[i] <= 32'h0;
         end
         else
         begin
            if (hit[i].rise)
               rcnt_q[i] <= rcnt_q[i] + 32'h1;
            if (hit[i].fall)
               fcnt_q[i] <= fcnt_q[i] + 32'h1;
         end
      end

      always_ff @(posedge CORE_CLK or negedge NRST)
      begin
         if (!NRST)
         begin
            rflag_q[i] <= 1'b0;
            fflag_q[i] <= 1'b0;
         end
         else
         begin
            if (hit[i].rise)
               rflag_q[i] <= 1'b1;
            else if (chg_now[i] || st_q[i] == PPL_DISABLED)
               rflag_q[i] <= 1'b0;
            if (hit[i].fall)
               fflag_q[i] <= 1'b1;
            else if (chg_now[i] || st_q[i] == PPL_DISABLED)
               fflag_q[i] <= 1'b0;
         end
      end

      // -------------------------------------------------------------
      // checks
      // -------------------------------------------------------------
      sequence s_toggle;
         !cfg[i].enable ##1 cfg[i].enable;
      endsequence

      sequence s_single_hit;
         (hit[i].rise || hit[i].fall) && !cfg[i].cont_mode && cfg[i].enable;
      endsequence

      a_rise_pos_capture : assert property (
         hit[i].rise |=> rpos_q[i] == $past(POSITION))
         else $error("rise position not captured");

      a_fall_pos_capture : assert property (
         hit[i].fall |=> fpos_q[i] == $past(POSITION))
         else $error("fall position not captured");

      a_rise_count_step : assert property (
         hit[i].rise |=> rcnt_q[i] == $past(rcnt_q[i]) + 32'h1)
         else $error("rise counter did not step");

      a_fall_count_step : assert property (
         hit[i].fall |=> fcnt_q[i] == $past(fcnt_q[i]) + 32'h1)
         else $error("fall counter did not step");

      a_single_once : assert property (
         s_single_hit |=> st_q[i] == PPL_SPENT && !hit[i].rise && !hit[i].fall)
         else $error("single mode did not stop after capture");

      a_rearm_toggle : assert property (
         s_toggle ##1 cfg[i].enable |-> st_q[i] == PPL_ARMED)
         else $error("enable toggle did not re-arm");

      a_hold_position : assert property (
         !hit[i].rise |=> rpos_q[i] == $past(rpos_q[i]))
         else $error("rise position changed without trigger");

      a_cont_armed : assert property (
         (hit[i].rise || hit[i].fall) && cfg[i].cont_mode && cfg[i].enable
         |=> st_q[i] == PPL_ARMED)
         else $error("continuous mode left armed state");

      a_cfg_clears : assert property (
         chg_now[i] |=> rcnt_q[i] == 32'h0 && fcnt_q[i] == 32'h0
                        && !rflag_q[i] && !fflag_q[i])
         else $error("settings change did not clear channel");

      a_flag_on_hit : assert property (
         hit[i].rise |=> status_w[i*8 + 1] ##1 (status_w[i*8 + 1] || $past(chg_now[i])
                                               || !cfg[i].enable))
         else $error("rise flag not shown in status");

      a_disable_clears : assert property (
         !cfg[i].enable ##1 !cfg[i].enable |=> !rflag_q[i] && !fflag_q[i])
         else $error("flags stayed set while disabled");
   end

endmodule : ppl_probe_latch

// *** probe_position_latch_tb_top.sv ***
// self-checking bench of the probe position latch: apb access, latch modes, irq
// assumes ppl_consts.svh and ppl_pkg are compiled; assertions live in the design
`timescale 1ns/1ps
`include "ppl_consts.svh"

module probe_position_latch_tb_top
   import ppl_pkg::*;
;
   typedef struct packed {
      logic [15:0] idx;
      logic [31:0] val;
   } ppl_row_s;

   logic        core_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin_one;
   logic        pin_two;
   logic        enc_index;
   logic [31:0] position;
   logic        irq;
   logic [31:0] rdat;
   logic        rerr;
   int          num_errors;
   int          comparisons;
   ppl_row_s    rows [13];

   ppl_probe_latch u_dut
   (
      .CORE_CLK        (core_clk),
      .NRST            (nrst),
      .PSEL            (psel),
      .PENABLE         (penable),
      .PWRITE          (pwrite),
      .PADDR           (paddr),
      .PWDATA          (pwdata),
      .PSTRB           (pstrb),
      .PRDATA          (prdata),
      .PREADY          (pready),
      .PSLVERR         (pslverr),
      .PROBE_INPUT_ONE (pin_one),
      .PROBE_INPUT_TWO (pin_two),
      .ENC_INDEX       (enc_index),
      .POSITION        (position),
      .IRQ             (irq)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // checking and apb tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // entered just after a rising edge; holds the request until pready
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      bit done;
      done = 1'b0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {14'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (int i = 0; i < 50 && !done; i++)
      begin
         @(posedge core_clk);
         done = (pready === 1'b1);
         rdat = prdata;
         rerr = pslverr;
      end
      if (!done)
         chk(32'h0, 32'h1, "no pready");
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdat, exp, $sformatf("read %h", idx));
      chk({31'h0, rerr}, 32'h0, "read error");
   endtask : rd

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic err);
      apb(1'b1, idx, wd);
      chk({31'h0, rerr}, {31'h0, err}, $sformatf("write error %h", idx));
   endtask : wr

   task automatic tgl(input int sel);
      case (sel)
         1:       pin_one   <= ~pin_one;
         2:       pin_two   <= ~pin_two;
         default: enc_index <= ~enc_index;
      endcase
      repeat (10) @(posedge core_clk);
   endtask : tgl

   // two level changes, position held steady across both
   task automatic pulse(input int sel, input logic [31:0] pos);
      position <= pos;
      tgl(sel);
      tgl(sel);
   endtask : pulse

   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   initial
   begin
      #20000;
      chk(32'h0, 32'h1, "watchdog expired");
      results();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 32'h0; pwdata = 32'h0; pstrb = 4'hf; position = 32'h0;
      pin_one = 1'b0; pin_two = 1'b0; enc_index = 1'b0;
      num_errors = 0; comparisons = 0;
      rows = '{'{`PPL_IDX_POLARITY, 32'h3}, '{`PPL_IDX_CTRL, 32'h0},
               '{`PPL_IDX_STATUS, 32'h0}, '{`PPL_IDX_P1_RPOS, 32'h0},
               '{`PPL_IDX_P1_FPOS, 32'h0}, '{`PPL_IDX_P2_RPOS, 32'h0},
               '{`PPL_IDX_P2_FPOS, 32'h0}, '{`PPL_IDX_P1_RCNT, 32'h0},
               '{`PPL_IDX_P1_FCNT, 32'h0}, '{`PPL_IDX_P2_RCNT, 32'h0},
               '{`PPL_IDX_P2_FCNT, 32'h0}, '{`PPL_IDX_IRQ_STAT, 32'h0},
               '{`PPL_IDX_IRQ_MASK, 32'h0}};
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq after reset");
      foreach (rows[i])
         rd(rows[i].idx, rows[i].val);
      // unmapped and read-only places refuse
      apb(1'b0, 16'h1234, 32'h0);
      chk({31'h0, rerr}, 32'h1, "unmapped read");
      wr(`PPL_IDX_STATUS, 32'hffff, 1'b1);
      wr(`PPL_IDX_P1_RCNT, 32'h5, 1'b1);
      rd(`PPL_IDX_P1_RCNT, 32'h0);
      // single trigger on channel 1, rising edge of probe one
      wr(`PPL_IDX_IRQ_MASK, 32'h1, 1'b0);
      wr(`PPL_IDX_CTRL, 32'h0011, 1'b0);
      rd(`PPL_IDX_STATUS, 32'h0001);
      pulse(1, 32'h1234_5678);
      rd(`PPL_IDX_P1_RPOS, 32'h1234_5678);
      rd(`PPL_IDX_P1_RCNT, 32'h1);
      rd(`PPL_IDX_P1_FCNT, 32'h0);
      rd(`PPL_IDX_STATUS, 32'h0003);
      chk({31'h0, irq}, 32'h1, "irq on rise");
      // a second trigger is ignored while spent
      pulse(1, 32'h0bad_0001);
      rd(`PPL_IDX_P1_RPOS, 32'h1234_5678);
      rd(`PPL_IDX_P1_RCNT, 32'h1);
      wr(`PPL_IDX_IRQ_STAT, 32'h1, 1'b0);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      // disable then enable re-arms and clears
      wr(`PPL_IDX_CTRL, 32'h0010, 1'b0);
      rd(`PPL_IDX_STATUS, 32'h0000);
      rd(`PPL_IDX_P1_RCNT, 32'h0);
      wr(`PPL_IDX_CTRL, 32'h0011, 1'b0);
      pulse(1, 32'h0000_00c3);
      rd(`PPL_IDX_P1_RPOS, 32'h0000_00c3);
      rd(`PPL_IDX_P1_RCNT, 32'h1);
      wr(`PPL_IDX_IRQ_STAT, 32'hf, 1'b0);
      // channel 2 continuous on the index pulse, both edges
      wr(`PPL_IDX_CTRL, 32'h3711, 1'b0);
      pulse(0, 32'hffff_fff0);
      pulse(0, 32'h8000_0000);
      rd(`PPL_IDX_P2_RPOS, 32'h8000_0000);
      rd(`PPL_IDX_P2_FPOS, 32'h8000_0000);
      rd(`PPL_IDX_P2_RCNT, 32'h2);
      rd(`PPL_IDX_P2_FCNT, 32'h2);
      rd(`PPL_IDX_STATUS, 32'h0703);
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(`PPL_IDX_IRQ_MASK, 32'hc, 1'b0);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      // channel 1 continuous on an active-low probe one
      wr(`PPL_IDX_CTRL, 32'h3700, 1'b0);
      wr(`PPL_IDX_POLARITY, 32'h2, 1'b0);
      rd(`PPL_IDX_POLARITY, 32'h2);
      tgl(1);
      wr(`PPL_IDX_CTRL, 32'h3713, 1'b0);
      rd(`PPL_IDX_CTRL, 32'h3713);
      pulse(0, 32'h0000_0077);
      rd(`PPL_IDX_P1_RCNT, 32'h0);
      pulse(1, 32'h0000_0011);
      pulse(1, 32'h0000_0022);
      rd(`PPL_IDX_P1_RPOS, 32'h0000_0022);
      rd(`PPL_IDX_P1_RCNT, 32'h2);
      rd(`PPL_IDX_P1_FCNT, 32'h0);
      rd(`PPL_IDX_P2_RCNT, 32'h3);
      // reserved control bits read zero
      wr(`PPL_IDX_CTRL, 32'hffff, 1'b0);
      rd(`PPL_IDX_CTRL, 32'h3737);
      results();
   end

endmodule : probe_position_latch_tb_top
